// ---- test/laeac_adc_model.sv ----
// Purpose: Converter stand-in that counts conversion starts.
// Assumes: A start pulse lasts one cycle.
// Notes:   Conversion itself is not modelled, only its launch and channel.
`timescale 1ns/1ns
module laeac_adc_model
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       adc_start,
  input  wire logic [4:0] adc_channel_select,
  output logic      [7:0] conv_count,
  output logic      [4:0] conv_channel
);
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      conv_count <= 8'h00;
    else if (adc_start)
    begin
      conv_count   <= conv_count + 8'h01;
      conv_channel <= adc_channel_select;
    end
  end
endmodule

// ---- test/laeac_asserts.sv ----
// Purpose: Port checks for the lock and memory/ADC control bank.
// Assumes: One slave; hready is the slave's own hreadyout.
// Notes:   Lock bits are shadowed from observed writes, as no port shows them.
`timescale 1ns/1ns
module laeac_asserts
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        stay_in_nvm_state,
  input wire logic        nvm_reload_request,
  input wire logic [4:0]  adc_channel_select,
  input wire logic        adc_start,
  input wire logic [5:0]  clear_command_pulse,
  input wire logic [7:0]  config_value
);
  logic       dw;
  logic       dr;
  logic [7:0] di;
  logic [3:0] lk;
  // ====================================================================
  // Shadow of the data phase in flight and of the lock bits.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      dw <= 1'b0;
      dr <= 1'b0;
      lk <= 4'hF;
    end
    else
    begin
      if (hready)
      begin
        dw <= hsel && htrans[1] && hwrite;
        dr <= hsel && htrans[1] && !hwrite;
        di <= haddr[9:2];
      end
      if (dw && hready && di == 8'h61)
      begin
        lk <= hwdata[3:0];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence wr_done(logic [7:0] idx); dw && hready && di == idx; endsequence
  sequence rd_done(logic [7:0] idx); dr && hready && di == idx; endsequence
  AST_STAY: assert property (wr_done(8'h62) |=> stay_in_nvm_state == $past(hwdata[7]))
    else $error("stay bit does not follow write");
  AST_RELOAD: assert property (wr_done(8'h62) |=> nvm_reload_request == $past(hwdata[6]))
    else $error("reload pulse does not follow write");
  AST_ADC_GO: assert property (wr_done(8'h62) |=> adc_start && adc_channel_select == $past(hwdata[4:0]))
    else $error("channel write did not start conversion");
  AST_ADC_CAUSE: assert property (adc_start |-> $past(dw && hready && di == 8'h62))
    else $error("conversion started without a write");
  AST_CLEAR: assert property (wr_done(8'h60) |=> clear_command_pulse == ($past(lk[3]) ? 6'h00 : $past(hwdata[5:0])))
    else $error("clear pulse wrong for lock state");
  AST_CLEAR_SELF: assert property (clear_command_pulse != 6'h00 |=> clear_command_pulse == 6'h00 || $past(dw && hready && di == 8'h60))
    else $error("clear pulse did not self clear");
  AST_CONFIG_GUARD: assert property ($changed(config_value) |-> $past(dw && hready && di == 8'h50 && !lk[2]))
    else $error("config changed while locked or unwritten");
  AST_LOCK_READ: assert property (rd_done(8'h61) |-> hrdata == {28'h0, lk})
    else $error("lock readback wrong");
  AST_MISC_READ: assert property (rd_done(8'h62) |-> hrdata == {24'h0, stay_in_nvm_state, 2'b00, adc_channel_select})
    else $error("misc readback wrong");
endmodule
bind laeac_top laeac_asserts i_chk (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .stay_in_nvm_state(stay_in_nvm_state), .nvm_reload_request(nvm_reload_request),
  .adc_channel_select(adc_channel_select), .adc_start(adc_start),
  .clear_command_pulse(clear_command_pulse), .config_value(config_value));

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the lock and memory/ADC control bank.
// Assumes: Single-word AHB-Lite transfers, index times four is the address.
// Notes:   Samples one step after an edge so registered updates have landed.
`timescale 1ns/1ns
module tb_top;
  logic        clk, reset_n, hsel, hwrite, hreadyout, hresp, stay, rld, adc_start;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [4:0]  ach, cch;
  logic [5:0]  clr;
  logic [7:0]  cfg, cnt, m7;
  int          err_count, total_checks, cyc;
  laeac_top i_dut (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .stay_in_nvm_state(stay),
    .nvm_reload_request(rld), .adc_channel_select(ach), .adc_start,
    .clear_command_pulse(clr), .config_value(cfg), .clock_misc_value(m7));
  laeac_adc_model i_adc (.clk, .reset_n, .adc_start, .adc_channel_select(ach),
    .conv_count(cnt), .conv_channel(cch));
  // ====================================================================
  // Bus and compare helpers.
  task xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {22'h0, i, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    #1;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ====================================================================
  // Scenarios.
  task t_reset;
    xfer(0, 8'h61, 8'h00); chk(q, 32'h0F);
    xfer(0, 8'h62, 8'h00); chk(q, 32'h00);
    chk(32'(stay), 32'h0);
    xfer(0, 8'h60, 8'h00); chk(q, 32'h00);
    // All locks are set here, yet a register outside the guarded groups must still take writes.
    xfer(1, 8'h63, 8'hFF); chk(32'(m7), 32'h33);
  endtask
  task t_guard;
    xfer(1, 8'h61, 8'h08); xfer(1, 8'h50, 8'h5A); chk(32'(cfg), 32'h5A);
    xfer(1, 8'h60, 8'h3F); chk(32'(clr), 32'h00);
    chk(32'(hresp), 32'h0);
    xfer(1, 8'h61, 8'h04); xfer(0, 8'h61, 8'h00); chk(q, 32'h04);
    xfer(1, 8'h50, 8'hA5); chk(32'(cfg), 32'h5A);
    xfer(1, 8'h60, 8'h2A); chk(32'(clr), 32'h2A);
    @(posedge clk) #1 chk(32'(clr), 32'h00);
  endtask
  task t_store;
    logic [7:0] idx [3];
    logic [7:0] msk [3];
    idx = '{8'h2B, 8'h3B, 8'h4B};
    msk = '{8'h02, 8'h01, 8'h01};
    for (int g = 0; g < 3; g++)
    begin
      xfer(1, 8'h61, 8'h00); xfer(1, idx[g], 8'h10 + 8'(g));
      xfer(0, idx[g], 8'h00); chk(q, 32'h10 + 32'(g));
      xfer(1, 8'h61, msk[g]); xfer(1, idx[g], 8'hE7);
      xfer(0, idx[g], 8'h00); chk(q, 32'h10 + 32'(g));
    end
  endtask
  task t_misc;
    logic [7:0] n;
    n = cnt;
    xfer(1, 8'h62, 8'hFF); chk(32'(rld), 32'h1);
    chk(32'(stay), 32'h1);
    chk(32'({adc_start, ach}), 32'h3F);
    @(posedge clk) #1 chk(32'(rld), 32'h0);
    chk(32'({cnt, cch}), 32'({n + 8'h01, 5'h1F}));
    xfer(0, 8'h62, 8'h00); chk(q, 32'h9F);
    xfer(1, 8'h62, 8'h03); chk(32'({stay, adc_start, ach}), 32'h23);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    reset_n <= 1'b0; hsel <= 1'b0; htrans <= 2'b00; hwrite <= 1'b0;
    hsize <= 3'h2; haddr <= 32'h0; hwdata <= 32'h0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_guard;
    t_store;
    t_misc;
    tally_and_finish;
  end
endmodule

// ---- verilog/laeac_pkg.sv ----
// Purpose: Types shared by the lock and memory/ADC control bank.
// Assumes: Nothing beyond the constants header.
// Notes:   Carrier structs for the protected group write ports.
package laeac_pkg;

  // ====================================================================
  // Write strobe towards a protected register group
  typedef struct packed {
    logic       we;
    logic [3:0] sel;
    logic [7:0] data;
  } laeac_wr_s;

  typedef enum logic [1:0] {
    LAEAC_IDLE,
    LAEAC_DATA
  } laeac_phase_e;

  typedef logic [7:0] laeac_byte_t;

endpackage

// ---- verilog/laeac_regs.svh ----
// Purpose: Offsets, field positions, reset values for the lock and memory/ADC control bank.
// Assumes: Byte offsets sit on word boundaries only after scaling by four.
// Notes:   Offsets are register indices; byte address is four times the index.
`ifndef LAEAC_REGS_SVH
`define LAEAC_REGS_SVH

// ====================================================================
// Register indices
`define LAEAC_IDX_CLEAR     8'h60
`define LAEAC_IDX_LOCK      8'h61
`define LAEAC_IDX_MISC6     8'h62
`define LAEAC_IDX_MISC7     8'h63
`define LAEAC_IDX_CONFIG    8'h50
`define LAEAC_IDX_CURRENT   8'h20
`define LAEAC_IDX_DUTY_HIGH 8'h30
`define LAEAC_IDX_DUTY_LOW  8'h40
`define LAEAC_CHANNELS      12

// ====================================================================
// Reset values and masks
`define LAEAC_LOCK_RESET    8'h0F
`define LAEAC_LOCK_MASK     8'h0F
`define LAEAC_MISC6_RESET   8'h00
`define LAEAC_MISC6_MASK    8'hDF
`define LAEAC_MISC7_MASK    8'h33
`define LAEAC_CLEAR_MASK    8'h3F

// ====================================================================
// Field positions
`define LAEAC_BIT_CMD_LOCK  3
`define LAEAC_BIT_CFG_LOCK  2
`define LAEAC_BIT_CUR_LOCK  1
`define LAEAC_BIT_DUTY_LOCK 0
`define LAEAC_BIT_STAY      7
`define LAEAC_BIT_RELOAD    6
`define LAEAC_ADC_MSB       4

`endif

// ---- verilog/laeac_store.sv ----
// Purpose: Small memory holding the per-channel current and duty bytes.
// Assumes: One write and one read port, registered read data.
// Notes:   Address is group in bits 5:4 and channel in bits 3:0.
`timescale 1ns/1ns
module laeac_store
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       we,
  input  wire logic [5:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [5:0] raddr,
  output logic      [7:0] rdata
);

  logic [7:0] mem [0:63];

  // ====================================================================
  // Storage
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    if (!reset_n)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ---- verilog/laeac_top.sv ----
// Purpose: Lock register, memory/ADC control and guarded register groups on AHB-Lite.
// Assumes: Single whole-word transfers; every answer is OKAY.
// Notes:   Writes complete in the data phase; reads wait one cycle for memory data.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ns
`include "laeac_regs.svh"
module laeac_top
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             stay_in_nvm_state,
  output logic             nvm_reload_request,
  output logic [4:0]       adc_channel_select,
  output logic             adc_start,
  output logic [5:0]       clear_command_pulse,
  output logic [7:0]       config_value,
  output logic [7:0]       clock_misc_value
);

  import laeac_pkg::*;

  // ====================================================================
  // State
  typedef struct packed {
    laeac_phase_e phase;
    logic         wr;
    logic [7:0]   idx;
    logic         rd_wait;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic [7:0]   lock;
    logic [7:0]   misc6;
    logic [7:0]   misc7;
    logic [7:0]   config_reg;
    logic         adc_start;
    logic [5:0]   clear_pulse;
  } laeac_state_s;

  laeac_state_s st;
  laeac_state_s next_st;

  logic [5:0] store_waddr;
  logic [5:0] store_raddr;
  logic       store_we;
  logic [7:0] store_rdata;

  // Decode an index into the per-channel store; bit 6 flags a hit.
  function automatic logic [6:0] store_map(input logic [7:0] idx);
    logic [6:0] r;
    r = 7'h00;
    if (idx[3:0] < 4'(`LAEAC_CHANNELS))
    begin
      if (idx[7:4] == `LAEAC_IDX_CURRENT >> 4)
      begin
        r = {1'b1, 2'd0, idx[3:0]};
      end
      else if (idx[7:4] == `LAEAC_IDX_DUTY_HIGH >> 4)
      begin
        r = {1'b1, 2'd1, idx[3:0]};
      end
      else if (idx[7:4] == `LAEAC_IDX_DUTY_LOW >> 4)
      begin
        r = {1'b1, 2'd2, idx[3:0]};
      end
    end
    return r;
  endfunction

  // Lock bit that guards a given store group.
  function automatic logic group_locked(input logic [1:0] grp, input logic [7:0] lk);
    logic r;
    r = (grp == 2'd0) ? lk[`LAEAC_BIT_CUR_LOCK] : lk[`LAEAC_BIT_DUTY_LOCK];
    return r;
  endfunction

  logic [6:0] wmap;
  logic [6:0] rmap;
  assign wmap        = store_map(st.idx);
  assign rmap        = store_map(haddr[9:2]);
  assign store_waddr = wmap[5:0];
  assign store_raddr = rmap[5:0];
  assign store_we    = (st.phase == LAEAC_DATA) && st.wr && wmap[6]
                       && !group_locked(wmap[5:4], st.lock);

  laeac_store u_store
  (
    .clk     (clk),
    .reset_n (reset_n),
    .we      (store_we),
    .waddr   (store_waddr),
    .wdata   (hwdata[7:0]),
    .raddr   (store_raddr),
    .rdata   (store_rdata)
  );

  // ====================================================================
  // Next state
  always_comb
  begin
    logic [7:0] rv;
    logic [7:0] d;
    rv = 8'h00;
    d  = hwdata[7:0];
    next_st = st;
    // Action strobes last one cycle; the reload bit reads back as zero at once.
    next_st.adc_start    = 1'b0;
    next_st.clear_pulse  = 6'h00;
    next_st.misc6[`LAEAC_BIT_RELOAD] = 1'b0;
    next_st.hreadyout    = 1'b1;
    next_st.rd_wait      = 1'b0;
    case (st.phase)
      LAEAC_IDLE:
      begin
        next_st.phase = LAEAC_IDLE;
      end
      LAEAC_DATA:
      begin
        next_st.phase = LAEAC_IDLE;
        if (st.wr)
        begin
          case (st.idx)
            `LAEAC_IDX_LOCK:
            begin
              next_st.lock = d & `LAEAC_LOCK_MASK;
            end
            `LAEAC_IDX_MISC6:
            begin
              next_st.misc6 = d & `LAEAC_MISC6_MASK;
              next_st.adc_start = 1'b1;
            end
            `LAEAC_IDX_MISC7:
            begin
              next_st.misc7 = d & `LAEAC_MISC7_MASK;
            end
            `LAEAC_IDX_CLEAR:
            begin
              if (!st.lock[`LAEAC_BIT_CMD_LOCK])
              begin
                next_st.clear_pulse = d[5:0] & 6'(`LAEAC_CLEAR_MASK);
              end
            end
            `LAEAC_IDX_CONFIG:
            begin
              if (!st.lock[`LAEAC_BIT_CFG_LOCK])
              begin
                next_st.config_reg = d;
              end
            end
            default:
            begin
              next_st.config_reg = st.config_reg;
            end
          endcase
        end
      end
      default:
      begin
        next_st.phase = LAEAC_IDLE;
      end
    endcase
    // Store reads need one extra cycle because the memory output is registered.
    if (st.rd_wait)
    begin
      next_st.hrdata = {24'h000000, store_rdata};
    end
    if (hsel && hready && htrans[1])
    begin
      next_st.phase = LAEAC_DATA;
      next_st.wr    = hwrite;
      next_st.idx   = haddr[9:2];
      if (!hwrite)
      begin
        case (haddr[9:2])
          `LAEAC_IDX_LOCK:  rv = st.lock;
          `LAEAC_IDX_MISC6: rv = st.misc6 & 8'hBF;
          `LAEAC_IDX_MISC7: rv = st.misc7;
          `LAEAC_IDX_CONFIG: rv = st.config_reg;
          default:          rv = 8'h00;
        endcase
        next_st.hrdata = {24'h000000, rv};
        if (rmap[6])
        begin
          next_st.rd_wait   = 1'b1;
          next_st.hreadyout = 1'b0;
        end
      end
    end
  end

  // ====================================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st           <= '0;
      st.phase     <= LAEAC_IDLE;
      st.hreadyout <= 1'b1;
      st.lock      <= `LAEAC_LOCK_RESET;
      st.misc6     <= `LAEAC_MISC6_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign hrdata              = st.hrdata;
  assign hreadyout           = st.hreadyout;
  assign hresp               = 1'b0;
  assign stay_in_nvm_state   = st.misc6[`LAEAC_BIT_STAY];
  assign nvm_reload_request  = st.misc6[`LAEAC_BIT_RELOAD];
  assign adc_channel_select  = st.misc6[`LAEAC_ADC_MSB:0];
  assign adc_start           = st.adc_start;
  assign clear_command_pulse = st.clear_pulse;
  assign config_value        = st.config_reg;
  assign clock_misc_value    = st.misc7;

endmodule
